// ### rtl/tls_pkg.sv
package tls_pkg;

  // Register byte offsets
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_LIM1 = 8'h04;
  localparam logic [7:0] A_LIM4 = 8'h10;
  localparam logic [7:0] A_IN_LO = 8'h14;
  localparam logic [7:0] A_IN_HI = 8'h18;
  localparam logic [7:0] A_OUT = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_IRQ_STAT = 8'h24;
  localparam logic [7:0] A_IRQ_CLR = 8'h28;
  localparam logic [7:0] A_IRQ_EN = 8'h2c;

  // Configuration register layout
  localparam int CFG_METHOD_LSB = 0;
  localparam int CFG_ALT_LSB = 4;
  localparam int CFG_ALT_SEL_BIT = 8;
  localparam int CFG_SRC_LSB = 16;
  localparam int CFG_REVP_BIT = 24;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h0107_0177;

  // Terminal assignment fields
  localparam int MF_FIELD_W = 6;
  localparam int MF_IN_LO_N = 5;
  localparam logic [29:0] MF_IN_LO_MASK = 30'h3fff_ffff;
  localparam logic [17:0] MF_IN_HI_MASK = 18'h3_ffff;
  localparam logic [29:0] MF_OUT_MASK = 30'h3fff_ffff;

  // Status register layout
  localparam int ST_ACTIVE_BIT = 8;
  localparam int ST_VECTOR_BIT = 9;
  localparam int ST_REV_BIT = 10;

  // Interrupt bits
  localparam int IRQ_CLAMP = 0;
  localparam int IRQ_REV = 1;
  localparam int IRQ_N = 2;

  // Control method codes
  localparam logic [2:0] M_SLV = 3'h3;
  localparam logic [2:0] M_ZSLV = 3'h4;
  localparam logic [2:0] M_SV = 3'h5;

  // Limit sources
  typedef enum logic [2:0] {
    SRC_QUAD = 3'b000,
    SRC_TERM = 3'b001,
    SRC_ANALOG = 3'b010,
    SRC_OPT1 = 3'b011,
    SRC_OPT2 = 3'b100
  } tls_src_t;

  // Terminal function codes
  localparam logic [5:0] MF_LIMIT_EN = 6'h28;
  localparam logic [5:0] MF_SW1 = 6'h29;
  localparam logic [5:0] MF_SW2 = 6'h2a;
  localparam logic [5:0] MF_OUT_LIMIT = 6'h0a;

  // Percent values
  localparam logic [7:0] PCT_DEFAULT = 8'h96;
  localparam logic [7:0] PCT_MAX_SMALL = 8'hc8;
  localparam logic [7:0] PCT_MAX_LARGE = 8'hb4;
  localparam logic [7:0] PCT_DISABLED = 8'hff;

  // Scaling
  localparam logic [14:0] CUR_FULL = 15'h7fff;
  localparam logic [9:0] ADC_FULL = 10'h3ff;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// ### rtl/tls_sync.sv
module tls_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ### rtl/tls_top.sv
// What this block does
// - Limiting acts only in three vector methods
// - Source select: quadrant, terminal, analog, options
// - Limits 0..200 or 0..180, disabled, default 150
// - Quadrant mode picks limit by torque quadrant
// - Terminal mode limit applies in all quadrants
// - Analog 0..10 V maps to 0..200 percent
// - Input codes 40, 41, 42 decoded
// - Enable input off forces maximum limit
// - No enable input means always active
// - 200 percent equals maximum output current
// - Output code 10 shows active clamping
// - Option sources need board present
// - Reverse prevention select, default off, vector only
//
// The register offsets and register access over AHB-Lite were left to the implementer.
module tls_top
  import tls_pkg::*;
#(
  parameter bit LARGE_RATING = 1'b0
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Control terminals
  input wire logic [7:0] mf_in,
  output logic [4:0] mf_out,
  input wire logic [9:0] analog_limit_input,
  // Expansion board
  input wire logic opt_present,
  input wire logic [7:0] opt_limit_1,
  input wire logic [7:0] opt_limit_2,
  // Motor control core
  input wire logic rotation_fwd,
  input wire logic run_fwd,
  input wire logic signed [15:0] torque_req,
  input wire logic signed [15:0] rot_cmd,
  output logic signed [15:0] torque_out,
  output logic signed [15:0] rot_cmd_out,
  output logic limit_active_out,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [7:0] code_mask(input logic [47:0] f, input logic [5:0] code);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = (f[i*MF_FIELD_W +: MF_FIELD_W] == code);
    end
    return m;
  endfunction

  function automatic logic [7:0] pct_clip(input logic [7:0] v, input logic [7:0] mx);
    return ((v == PCT_DISABLED) || (v > mx)) ? mx : v;
  endfunction

  function automatic logic word_hit(input logic [5:0] a, input logic [7:0] off);
    return a == off[7:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [7:0] mf_in_q;
  logic [9:0] analog_q;
  logic opt_present_q;
  logic [7:0] opt1_q;
  logic [7:0] opt2_q;

  tls_sync #(.W(35)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({mf_in, analog_limit_input, opt_present, opt_limit_1, opt_limit_2}),
    .q({mf_in_q, analog_q, opt_present_q, opt1_q, opt2_q})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus slave

  logic [31:0] cfg_reg;
  logic [7:0] lim_reg [4];
  logic [29:0] in_lo_reg;
  logic [17:0] in_hi_reg;
  logic [29:0] out_reg;
  logic [IRQ_N-1:0] irq_stat_reg;
  logic [IRQ_N-1:0] irq_en_reg;
  logic [7:0] limit_pct_reg;
  logic vector_reg;
  logic rev_sup_reg;
  logic [5:0] addr_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [31:0] rd_mux;

  wire addr_ok = hsel & htrans[1] & hready;
  wire wr_cfg = wr_pend_reg & word_hit(addr_reg, A_CFG);
  wire wr_lim = wr_pend_reg & (addr_reg >= A_LIM1[7:2]) & (addr_reg <= A_LIM4[7:2]);
  wire [1:0] lim_idx = 2'(addr_reg - A_LIM1[7:2]);
  wire wr_in_lo = wr_pend_reg & word_hit(addr_reg, A_IN_LO);
  wire wr_in_hi = wr_pend_reg & word_hit(addr_reg, A_IN_HI);
  wire wr_out = wr_pend_reg & word_hit(addr_reg, A_OUT);
  wire wr_irq_clr = wr_pend_reg & word_hit(addr_reg, A_IRQ_CLR);
  wire wr_irq_en = wr_pend_reg & word_hit(addr_reg, A_IRQ_EN);
  wire [1:0] rd_lim_idx = 2'(addr_reg - A_LIM1[7:2]);
  wire rd_lim = (addr_reg >= A_LIM1[7:2]) & (addr_reg <= A_LIM4[7:2]);
  wire [31:0] stat_word = {21'h0, rev_sup_reg, vector_reg, limit_active_out, limit_pct_reg};

  assign rd_mux = word_hit(addr_reg, A_CFG) ? cfg_reg :
                  rd_lim ? {24'h0, lim_reg[rd_lim_idx]} :
                  word_hit(addr_reg, A_IN_LO) ? {2'h0, in_lo_reg} :
                  word_hit(addr_reg, A_IN_HI) ? {14'h0, in_hi_reg} :
                  word_hit(addr_reg, A_OUT) ? {2'h0, out_reg} :
                  word_hit(addr_reg, A_STAT) ? stat_word :
                  word_hit(addr_reg, A_IRQ_STAT) ? {30'h0, irq_stat_reg} :
                  word_hit(addr_reg, A_IRQ_EN) ? {30'h0, irq_en_reg} : 32'h0;

  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 6'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
    end else if (addr_ok) begin
      addr_reg <= haddr[7:2];
      wr_pend_reg <= hwrite & (hsize == HSIZE_WORD);
      rd_pend_reg <= ~hwrite;
      hreadyout <= hwrite;
    end else begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout <= 1'b1;
      if (rd_pend_reg) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= CFG_RESET;
      for (int i = 0; i < 4; i++) begin
        lim_reg[i] <= PCT_DEFAULT;
      end
      in_lo_reg <= 30'h0;
      in_hi_reg <= 18'h0;
      out_reg <= 30'h0;
      irq_en_reg <= '0;
    end else begin
      if (wr_cfg) cfg_reg <= hwdata & CFG_MASK;
      if (wr_lim) lim_reg[lim_idx] <= hwdata[7:0];
      if (wr_in_lo) in_lo_reg <= hwdata[29:0] & MF_IN_LO_MASK;
      if (wr_in_hi) in_hi_reg <= hwdata[17:0] & MF_IN_HI_MASK;
      if (wr_out) out_reg <= hwdata[29:0] & MF_OUT_MASK;
      if (wr_irq_en) irq_en_reg <= hwdata[IRQ_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and terminal decode

  wire [7:0] pct_max = LARGE_RATING ? PCT_MAX_LARGE : PCT_MAX_SMALL;
  wire [2:0] method = cfg_reg[CFG_ALT_SEL_BIT] ? cfg_reg[CFG_ALT_LSB +: 3] : cfg_reg[CFG_METHOD_LSB +: 3];
  wire vector_now = (method == M_SLV) | (method == M_ZSLV) | (method == M_SV);
  wire [2:0] src = cfg_reg[CFG_SRC_LSB +: 3];
  wire [47:0] in_fields = {in_hi_reg, in_lo_reg};
  wire [7:0] en_mask = code_mask(in_fields, MF_LIMIT_EN);
  wire [7:0] sw1_mask = code_mask(in_fields, MF_SW1);
  wire [7:0] sw2_mask = code_mask(in_fields, MF_SW2);
  wire [4:0] out_mask = 5'(code_mask({18'h0, out_reg}, MF_OUT_LIMIT));
  wire en_assigned = |en_mask;
  wire en_block = en_assigned & ~|(en_mask & mf_in_q);
  wire [1:0] sw_sel = {|(sw2_mask & mf_in_q), |(sw1_mask & mf_in_q)};

  ////////////////////////////////////////////////////////////////////////////
  // Limit selection

  logic [7:0] lim_eff [4];
  logic [7:0] sel_pct;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lim_eff[i] = pct_clip(lim_reg[i], pct_max);
    end
  end

  wire torque_pos = ~torque_req[15];
  wire [1:0] quad_idx = rotation_fwd ? (torque_pos ? 2'd0 : 2'd3) : (torque_pos ? 2'd1 : 2'd2);
  wire [17:0] an_prod = {8'h0, analog_q} * {10'h0, PCT_MAX_SMALL};
  wire [7:0] an_pct = 8'(an_prod / {8'h0, ADC_FULL});

  always_comb begin
    case (tls_src_t'(src))
      SRC_QUAD: sel_pct = lim_eff[quad_idx];
      SRC_TERM: sel_pct = lim_eff[sw_sel];
      SRC_ANALOG: sel_pct = an_pct;
      SRC_OPT1: sel_pct = opt_present_q ? pct_clip(opt1_q, pct_max) : pct_max;
      SRC_OPT2: sel_pct = opt_present_q ? pct_clip(opt2_q, pct_max) : pct_max;
      default: sel_pct = pct_max;
    endcase
    if (en_block) begin
      sel_pct = pct_max;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current scaling and clamp

  wire [23:0] cur_prod = {16'h0, sel_pct} * {9'h0, CUR_FULL};
  wire [15:0] lim_cur = 16'(cur_prod / {16'h0, PCT_MAX_SMALL});
  wire signed [16:0] req_x = {torque_req[15], torque_req};
  wire signed [16:0] lim_pos = {1'b0, lim_cur};
  wire signed [16:0] lim_neg = -lim_pos;
  wire over_hi = req_x > lim_pos;
  wire over_lo = req_x < lim_neg;
  wire clamp_next = vector_now & (over_hi | over_lo);
  wire signed [15:0] torque_next = !clamp_next ? torque_req : over_hi ? $signed(lim_cur) : lim_neg[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Reverse rotation prevention

  wire revp_on = cfg_reg[CFG_REVP_BIT] & vector_now;
  wire rev_sup_next = revp_on & (run_fwd ? rot_cmd < 0 : rot_cmd > 0);

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and interrupt status

  wire [IRQ_N-1:0] irq_ev = {rev_sup_next & ~rev_sup_reg, clamp_next & ~limit_active_out};
  wire [IRQ_N-1:0] irq_clr = wr_irq_clr ? hwdata[IRQ_N-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      torque_out <= 16'sh0;
      rot_cmd_out <= 16'sh0;
      limit_active_out <= 1'b0;
      mf_out <= 5'h00;
      limit_pct_reg <= 8'h00;
      vector_reg <= 1'b0;
      rev_sup_reg <= 1'b0;
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end else begin
      torque_out <= torque_next;
      rot_cmd_out <= rev_sup_next ? 16'sh0 : rot_cmd;
      limit_active_out <= clamp_next;
      mf_out <= out_mask & {5{clamp_next}};
      limit_pct_reg <= sel_pct;
      vector_reg <= vector_now;
      rev_sup_reg <= rev_sup_next;
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_vec_src(logic [2:0] s);
    vector_now && !en_block && src == s;
  endsequence

  a_inactive_nonvector: assert property (!vector_now |=> !limit_active_out && torque_out == $past(torque_req))
    else $error("limit acted outside vector methods");
  a_quad_select: assert property (s_vec_src(SRC_QUAD) ##0 !rotation_fwd && torque_pos
    |=> limit_pct_reg == $past(lim_eff[1]))
    else $error("reverse regeneration limit not chosen");
  a_term_select: assert property (s_vec_src(SRC_TERM) ##0 sw_sel == 2'b10
    |=> limit_pct_reg == $past(lim_eff[2]))
    else $error("switch code two did not pick limit three");
  a_analog_full: assert property (s_vec_src(SRC_ANALOG) ##0 analog_q == ADC_FULL
    |=> limit_pct_reg == PCT_MAX_SMALL)
    else $error("full scale analog not 200 percent");
  a_enable_gate: assert property (en_block |=> limit_pct_reg == pct_max)
    else $error("enable off did not force maximum");
  a_option_absent: assert property ((src == SRC_OPT1 || src == SRC_OPT2) && !opt_present_q
    |=> limit_pct_reg == pct_max)
    else $error("option source used without board");
  a_clamp_bound: assert property (limit_active_out |-> torque_out == $past(lim_cur) ||
    torque_out == -$signed({1'b0, $past(lim_cur)}))
    else $error("clamped torque not at the limit");
  a_flag_output: assert property ($stable(out_reg) |-> mf_out == (out_mask & {5{limit_active_out}}))
    else $error("limit flag output mismatch");
  a_reverse_block: assert property (revp_on && run_fwd && rot_cmd < 0 |=> rot_cmd_out == 16'sh0)
    else $error("reverse rotation passed");
  a_disabled_max: assert property (s_vec_src(SRC_QUAD) ##0 lim_reg[quad_idx] == PCT_DISABLED
    |=> limit_pct_reg == pct_max)
    else $error("disabled limit not at maximum");

endmodule

// ### tb/tls_core_model.sv
module tls_core_model (
  // Clock
  input wire logic hclk,
  // Toward the limit block
  output logic rotation_fwd,
  output logic run_fwd,
  output logic signed [15:0] torque_req,
  output logic signed [15:0] rot_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rotation_fwd = 1'b1;
    run_fwd = 1'b1;
    torque_req = 16'h0000;
    rot_cmd = 16'h0000;
  end

  // New request right after an edge, held until the next call
  task automatic drive(input logic fwd, input logic run, input logic [15:0] t, input logic [15:0] r);
    @(posedge hclk);
    rotation_fwd <= fwd;
    run_fwd <= run;
    torque_req <= t;
    rot_cmd <= r;
  endtask
endmodule

// ### tb/tls_top_bench.sv
module tls_top_bench
  import tls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] mf_in = 8'h00;
  logic [9:0] analog_limit_input = 10'h000;
  logic opt_present = 1'b0;
  logic [7:0] opt_limit_1 = 8'h00;
  logic [7:0] opt_limit_2 = 8'h00;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [4:0] mf_out;
  logic rotation_fwd;
  logic run_fwd;
  logic signed [15:0] torque_req;
  logic signed [15:0] rot_cmd;
  logic signed [15:0] torque_out;
  logic signed [15:0] rot_cmd_out;
  logic limit_active_out;
  logic irq;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic [7:0] pcts [4] = '{8'h64, 8'h32, 8'h14, PCT_DISABLED};
  logic [15:0] q_req [4] = '{16'h7000, 16'h7000, 16'h9000, 16'h9000};
  logic [3:0] q_fwd = 4'b1001;
  logic [15:0] q_exp [4] = '{16'h3fff, 16'h1fff, 16'hf334, 16'h9000};
  logic [15:0] t_exp [4] = '{16'hc001, 16'he001, 16'hf334, 16'h9000};

  always #5 hclk = ~hclk;

  tls_top u_tls_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mf_in, .mf_out, .analog_limit_input,
    .opt_present, .opt_limit_1, .opt_limit_2, .rotation_fwd, .run_fwd, .torque_req, .rot_cmd,
    .torque_out, .rot_cmd_out, .limit_active_out, .irq);

  tls_core_model u_core_model (.hclk, .rotation_fwd, .run_fwd, .torque_req, .rot_cmd);

  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready high at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: bus ready timeout", $time);
      close_out();
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task settle;
    repeat (4) @(posedge hclk);
    #1;
  endtask

  task out_is(input logic [15:0] t, input logic act);
    settle();
    chk({16'h0, torque_out}, {16'h0, t});
    chk({31'h0, limit_active_out}, {31'h0, act});
    chk({31'h0, mf_out[0]}, {31'h0, act});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, A_CFG, 0);
    chk(rd, CFG_RESET);
    chk({31'h0, hresp}, 32'h0);
    bus(0, A_LIM1, 0);
    chk(rd, {24'h0, PCT_DEFAULT});
    bus(0, 8'h3c, 0);
    chk(rd, 32'h0);
    bus(1, A_OUT, {26'h0, MF_OUT_LIMIT});
    u_core_model.drive(1, 1, 16'h7000, 16'h0);
    out_is(16'h7000, 0);
    bus(1, A_CFG, 32'h0000_0003);
    out_is(16'h5fff, 1);
    $display("method test done");
    for (int i = 0; i < 4; i++) begin
      bus(1, A_LIM1 + 8'(4 * i), {24'h0, pcts[i]});
      bus(0, A_LIM1 + 8'(4 * i), 0);
      chk(rd, {24'h0, pcts[i]});
    end
    for (int i = 0; i < 4; i++) begin
      u_core_model.drive(q_fwd[i], 1, q_req[i], 16'h0);
      out_is(q_exp[i], i < 3);
    end
    $display("quadrant test done");
    bus(1, A_IN_LO, 32'h0000_0aa9);
    bus(1, A_CFG, 32'h0001_0003);
    bus(1, A_IRQ_CLR, 32'h3);
    bus(1, A_IRQ_EN, 32'h1);
    u_core_model.drive(0, 1, 16'h9000, 16'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      mf_in <= 8'(i);
      out_is(t_exp[i], i < 3);
    end
    $display("terminal test done");
    @(posedge hclk);
    mf_in <= 8'h00;
    bus(1, A_IN_LO, 32'h0002_8aa9);
    out_is(16'h9000, 0);
    @(posedge hclk);
    mf_in <= 8'h04;
    out_is(16'hc001, 1);
    settle();
    chk({31'h0, irq}, 32'h1);
    bus(1, A_IRQ_CLR, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
    bus(1, A_IRQ_EN, 32'h0);
    @(posedge hclk);
    mf_in <= 8'h00;
    out_is(16'h9000, 0);
    @(posedge hclk);
    mf_in <= 8'h04;
    settle();
    settle();
    chk({31'h0, irq}, 32'h0);
    bus(0, A_IRQ_STAT, 0);
    chk(rd & 32'h1, 32'h1);
    $display("enable and interrupt test done");
    bus(1, A_CFG, 32'h0002_0003);
    u_core_model.drive(1, 1, 16'h7000, 16'h0);
    @(posedge hclk);
    analog_limit_input <= 10'h3ff;
    out_is(16'h7000, 0);
    @(posedge hclk);
    analog_limit_input <= 10'h200;
    out_is(16'h3fff, 1);
    bus(0, A_STAT, 0);
    chk(rd, 32'h0000_0364);
    bus(1, A_CFG, 32'h0003_0003);
    @(posedge hclk);
    opt_limit_1 <= 8'h3c;
    opt_limit_2 <= 8'h14;
    out_is(16'h7000, 0);
    @(posedge hclk);
    opt_present <= 1'b1;
    out_is(16'h2666, 1);
    bus(1, A_CFG, 32'h0004_0003);
    out_is(16'h0ccc, 1);
    $display("analog and option test done");
    bus(1, A_CFG, 32'h0100_0003);
    u_core_model.drive(1, 1, 16'h0, 16'hff9c);
    settle();
    chk({16'h0, rot_cmd_out}, 32'h0);
    bus(0, A_STAT, 0);
    chk(rd, 32'h0000_0664);
    bus(0, A_IRQ_STAT, 0);
    chk(rd & 32'h2, 32'h2);
    u_core_model.drive(1, 1, 16'h0, 16'h0064);
    settle();
    chk({16'h0, rot_cmd_out}, 32'h0064);
    u_core_model.drive(1, 0, 16'h0, 16'h0064);
    settle();
    chk({16'h0, rot_cmd_out}, 32'h0);
    bus(1, A_CFG, 32'h0100_0000);
    u_core_model.drive(1, 1, 16'h0, 16'hff9c);
    settle();
    chk({16'h0, rot_cmd_out}, 32'hff9c);
    $display("reverse test done");
    close_out();
  end
endmodule
